// ### design/etsc_pkg.sv
package etsc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Parameter offsets
    localparam logic [15:0] OFS_A_EDGE  = 16'h0141;
    localparam logic [15:0] OFS_A_MODE  = 16'h0142;
    localparam logic [15:0] OFS_A_LOW   = 16'h0143;
    localparam logic [15:0] OFS_A_HIGH  = 16'h0144;
    localparam logic [15:0] OFS_B_EDGE  = 16'h0145;
    localparam logic [15:0] OFS_B_MODE  = 16'h0146;
    localparam logic [15:0] OFS_B_LOW   = 16'h0147;
    localparam logic [15:0] OFS_B_HIGH  = 16'h0148;
    localparam logic [15:0] OFS_A_VALUE = 16'h0150;
    localparam logic [15:0] OFS_B_VALUE = 16'h0151;
    localparam logic [15:0] OFS_STATUS  = 16'h0152;
    localparam logic [15:0] OFS_REARM   = 16'h0153;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions in status and re-arm words
    localparam int BIT_A = 0;
    localparam int BIT_B = 1;

    ////////////////////////////////////////////////////////////////////////////
    // Edge selection and trigger mode codes
    typedef enum logic [1:0] {
        EDGE_OFF  = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_BOTH = 2'h3
    } etsc_edge_e;

    localparam logic MODE_SINGLE = 1'h0;
    localparam logic MODE_CONT   = 1'h1;

    ////////////////////////////////////////////////////////////////////////////
    // Source codes
    localparam int          NUM_SRC        = 12;
    localparam logic [15:0] SRC_FIRST_LOW  = 16'h0010;
    localparam logic [15:0] SRC_LAST_LOW   = 16'h0022;
    localparam logic [15:0] PHASE_LOW      = 16'h000F;
    localparam logic [15:0] PHASE_HIGH     = 16'h0057;
    localparam logic [15:0] STATOR_LOW     = 16'h0056;
    localparam logic [15:0] STATOR_HIGH    = 16'h0057;
    localparam logic [3:0]  SRC_IDX_AUX    = 4'h9;
    localparam logic [3:0]  SRC_IDX_PHASE  = 4'hA;
    localparam logic [3:0]  SRC_IDX_STATOR = 4'hB;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam etsc_edge_e  RST_EDGE = EDGE_OFF;
    localparam logic        RST_MODE = MODE_SINGLE;
    localparam logic [15:0] RST_LOW  = 16'h0010;
    localparam logic [15:0] RST_HIGH = 16'h0011;

    typedef struct packed {
        logic       ok;
        logic [3:0] idx;
    } etsc_src_s;

    // Low and high code only name a source as a pair
    function automatic etsc_src_s etsc_src_decode(input logic [15:0] lo, input logic [15:0] hi);
        etsc_src_s   r;
        logic [15:0] off;
        r.ok  = 1'b0;
        r.idx = 4'h0;
        off   = lo - SRC_FIRST_LOW;
        if (lo == PHASE_LOW && hi == PHASE_HIGH)
        begin
            r.ok  = 1'b1;
            r.idx = SRC_IDX_PHASE;
        end
        else if (lo == STATOR_LOW && hi == STATOR_HIGH)
        begin
            r.ok  = 1'b1;
            r.idx = SRC_IDX_STATOR;
        end
        else if (lo >= SRC_FIRST_LOW && lo <= SRC_LAST_LOW && !lo[0] && hi == lo + 16'h0001)
        begin
            r.ok  = 1'b1;
            r.idx = off[4:1];
        end
        return r;
    endfunction : etsc_src_decode

endpackage : etsc_pkg

// ### design/etsc_chan_if.sv
`timescale 1ns/100ps
interface etsc_chan_if
    import etsc_pkg::*;
#(
    parameter int DW = 32
)
();
    etsc_edge_e      edge_sel;
    logic            cont;
    logic            src_ok;
    logic [DW-1:0]   src_val;
    logic            rearm;
    logic            fire;
    logic            done;
    logic [DW-1:0]   value;

    modport ctl  (output edge_sel, cont, src_ok, src_val, rearm, input fire, done, value);
    modport chan (input edge_sel, cont, src_ok, src_val, rearm, output fire, done, value);
endinterface : etsc_chan_if

// ### design/etsc_chan.sv
`timescale 1ns/100ps
module etsc_chan
    import etsc_pkg::*;
#(
    parameter int DW = 32
)
(
    // Clock and reset
    input wire logic    clk,
    input wire logic    nrst,
    // Trigger pin
    input wire logic    cap_pin,
    // Configuration and result
    etsc_chan_if.chan   ch
);

    logic          sync1_q;
    logic          sync2_q;
    logic          prev_q;
    logic          rise;
    logic          fall;
    logic          hit;
    logic          fire;
    logic          done_q;
    logic [DW-1:0] value_q;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser; only sync2_q and later stages are looked at
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
        end
        else
        begin
            sync1_q <= cap_pin;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign rise = sync2_q & ~prev_q;
    assign fall = ~sync2_q & prev_q;

    always_comb
    begin
        case (ch.edge_sel)
            EDGE_RISE: hit = rise;
            EDGE_FALL: hit = fall;
            EDGE_BOTH: hit = rise | fall;
            default:   hit = 1'b0;
        endcase
    end

    // Single mode is blocked once done; continuous ignores done
    assign fire = hit && ch.src_ok && (ch.cont || !done_q);

    ////////////////////////////////////////////////////////////////////////////
    // Latched value stays until the next capture
    always_ff @(posedge clk)
    begin
        if (!nrst)
            value_q <= '0;
        else if (fire)
            value_q <= ch.src_val;
    end

    // A capture in the re-arm cycle wins so that edge is not lost
    always_ff @(posedge clk)
    begin
        if (!nrst)
            done_q <= 1'b0;
        else if (fire)
            done_q <= 1'b1;
        else if (ch.rearm)
            done_q <= 1'b0;
    end

    assign ch.fire  = fire;
    assign ch.done  = done_q;
    assign ch.value = value_q;

    AST_SET_WINS: assert property (@(posedge clk) disable iff (!nrst)
        (fire && ch.rearm) |=> done_q)
        else $error("capture in re-arm cycle lost its done flag");

endmodule : etsc_chan

// ### design/etsc_capture.sv
`timescale 1ns/100ps
module etsc_capture
    import etsc_pkg::*;
#(
    parameter int DW = 32
)
(
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          nrst,
    // Capture trigger pins
    input  wire logic                          cap_a_pin,
    input  wire logic                          cap_b_pin,
    // Drive quantities to capture
    input  wire logic [NUM_SRC-1:0][DW-1:0]    src_i,
    // Parameter access
    input  wire logic [15:0]                   param_addr,
    input  wire logic                          param_wr,
    input  wire logic [15:0]                   param_wdata,
    input  wire logic                          param_rd,
    output      logic [DW-1:0]                 param_rdata,
    output      logic                          param_rvalid,
    // Capture events
    output      logic                          cap_a_event,
    output      logic                          cap_b_event
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration check
    generate
        if (DW < 16 || DW > 64)
        begin : g_bad_dw
            $error("etsc_capture: DW must lie between 16 and 64");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    etsc_edge_e    a_edge_q;
    logic          a_mode_q;
    logic [15:0]   a_low_q;
    logic [15:0]   a_high_q;
    etsc_edge_e    b_edge_q;
    logic          b_mode_q;
    logic [15:0]   b_low_q;
    logic [15:0]   b_high_q;
    etsc_src_s     a_sel;
    etsc_src_s     b_sel;
    logic          wr_edge_ok;
    logic          wr_mode_ok;
    logic          wr_rearm;
    logic [DW-1:0] rd_word;
    logic [DW-1:0] rdata_q;
    logic          rvalid_q;
    logic          a_event_q;
    logic          b_event_q;

    etsc_chan_if #(.DW(DW)) ifa ();
    etsc_chan_if #(.DW(DW)) ifb ();

    ////////////////////////////////////////////////////////////////////////////
    // Write qualification: out-of-range codes leave the old setting
    assign wr_edge_ok = param_wr && (param_wdata[15:2] == 14'h0000);
    assign wr_mode_ok = param_wr && (param_wdata[15:1] == 15'h0000);
    assign wr_rearm   = param_wr && (param_addr == OFS_REARM);

    ////////////////////////////////////////////////////////////////////////////
    // Channel A settings
    always_ff @(posedge clk)
    begin
        if (!nrst)
            a_edge_q <= RST_EDGE;
        else if (wr_edge_ok && param_addr == OFS_A_EDGE)
            a_edge_q <= etsc_edge_e'(param_wdata[1:0]);
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            a_mode_q <= RST_MODE;
        else if (wr_mode_ok && param_addr == OFS_A_MODE)
            a_mode_q <= param_wdata[0];
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            a_low_q  <= RST_LOW;
            a_high_q <= RST_HIGH;
        end
        else if (param_wr)
        begin
            if (param_addr == OFS_A_LOW)
                a_low_q <= param_wdata;
            else if (param_addr == OFS_A_HIGH)
                a_high_q <= param_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel B settings, kept apart from A
    always_ff @(posedge clk)
    begin
        if (!nrst)
            b_edge_q <= RST_EDGE;
        else if (wr_edge_ok && param_addr == OFS_B_EDGE)
            b_edge_q <= etsc_edge_e'(param_wdata[1:0]);
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            b_mode_q <= RST_MODE;
        else if (wr_mode_ok && param_addr == OFS_B_MODE)
            b_mode_q <= param_wdata[0];
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            b_low_q  <= RST_LOW;
            b_high_q <= RST_HIGH;
        end
        else if (param_wr)
        begin
            if (param_addr == OFS_B_LOW)
                b_low_q <= param_wdata;
            else if (param_addr == OFS_B_HIGH)
                b_high_q <= param_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Source selection; an unknown pair disables capture rather than
    // latching some arbitrary quantity
    assign a_sel = etsc_src_decode(a_low_q, a_high_q);
    assign b_sel = etsc_src_decode(b_low_q, b_high_q);

    assign ifa.edge_sel = a_edge_q;
    assign ifa.cont     = (a_mode_q == MODE_CONT);
    assign ifa.src_ok   = a_sel.ok;
    assign ifa.src_val  = src_i[a_sel.idx];
    assign ifa.rearm    = wr_rearm && param_wdata[BIT_A];

    assign ifb.edge_sel = b_edge_q;
    assign ifb.cont     = (b_mode_q == MODE_CONT);
    assign ifb.src_ok   = b_sel.ok;
    assign ifb.src_val  = src_i[b_sel.idx];
    assign ifb.rearm    = wr_rearm && param_wdata[BIT_B];

    ////////////////////////////////////////////////////////////////////////////
    // Capture channels
    etsc_chan #(.DW(DW)) u_chan_a (
        .clk     (clk),
        .nrst    (nrst),
        .cap_pin (cap_a_pin),
        .ch      (ifa.chan)
    );

    etsc_chan #(.DW(DW)) u_chan_b (
        .clk     (clk),
        .nrst    (nrst),
        .cap_pin (cap_b_pin),
        .ch      (ifb.chan)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Event pulses line up with the new value becoming visible
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            a_event_q <= 1'b0;
            b_event_q <= 1'b0;
        end
        else
        begin
            a_event_q <= ifa.fire;
            b_event_q <= ifb.fire;
        end
    end

    assign cap_a_event = a_event_q;
    assign cap_b_event = b_event_q;

    ////////////////////////////////////////////////////////////////////////////
    // Read path
    always_comb
    begin
        rd_word = '0;
        if (param_addr == OFS_A_EDGE)
            rd_word = DW'(a_edge_q);
        else if (param_addr == OFS_A_MODE)
            rd_word = DW'(a_mode_q);
        else if (param_addr == OFS_A_LOW)
            rd_word = DW'(a_low_q);
        else if (param_addr == OFS_A_HIGH)
            rd_word = DW'(a_high_q);
        else if (param_addr == OFS_B_EDGE)
            rd_word = DW'(b_edge_q);
        else if (param_addr == OFS_B_MODE)
            rd_word = DW'(b_mode_q);
        else if (param_addr == OFS_B_LOW)
            rd_word = DW'(b_low_q);
        else if (param_addr == OFS_B_HIGH)
            rd_word = DW'(b_high_q);
        else if (param_addr == OFS_A_VALUE)
            rd_word = ifa.value;
        else if (param_addr == OFS_B_VALUE)
            rd_word = ifb.value;
        else if (param_addr == OFS_STATUS)
            rd_word = DW'({ifb.done, ifa.done});
        else
            rd_word = '0;
    end

    // Read data is registered; a read of the re-arm word returns zero
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            rdata_q  <= '0;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= param_rd;
            if (param_rd)
                rdata_q <= rd_word;
        end
    end

    assign param_rdata  = rdata_q;
    assign param_rvalid = rvalid_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence a_rise_seen;
        $rose(cap_a_pin) ##2
            ((ifa.edge_sel == EDGE_RISE || ifa.edge_sel == EDGE_BOTH) && ifa.cont && ifa.src_ok);
    endsequence

    sequence a_fall_seen;
        $fell(cap_a_pin) ##2
            ((ifa.edge_sel == EDGE_FALL || ifa.edge_sel == EDGE_BOTH) && ifa.cont && ifa.src_ok);
    endsequence

    sequence b_rise_seen;
        $rose(cap_b_pin) ##2
            ((ifb.edge_sel == EDGE_RISE || ifb.edge_sel == EDGE_BOTH) && ifb.cont && ifb.src_ok);
    endsequence

    AST_EDGE_OFF: assert property (@(posedge clk) disable iff (!nrst)
        (ifa.edge_sel == EDGE_OFF) |-> !ifa.fire)
        else $error("channel A captured with edge selection off");

    AST_RISE_A: assert property (@(posedge clk) disable iff (!nrst)
        a_rise_seen |-> ifa.fire)
        else $error("channel A missed a rising edge");

    AST_FALL_A: assert property (@(posedge clk) disable iff (!nrst)
        a_fall_seen |-> ifa.fire)
        else $error("channel A missed a falling edge");

    AST_SINGLE_BLOCK: assert property (@(posedge clk) disable iff (!nrst)
        (ifa.done && !ifa.cont) |-> !ifa.fire)
        else $error("channel A captured again in single mode");

    AST_SINGLE_DONE: assert property (@(posedge clk) disable iff (!nrst)
        (ifa.fire && !ifa.cont) |=> (ifa.done && cap_a_event))
        else $error("single capture did not set done");

    AST_LATCH_A: assert property (@(posedge clk) disable iff (!nrst)
        ifa.fire |=> (ifa.value == $past(ifa.src_val)))
        else $error("channel A latched the wrong value");

    AST_B_RISE: assert property (@(posedge clk) disable iff (!nrst)
        b_rise_seen |-> ifb.fire)
        else $error("channel B missed a rising edge");

    AST_B_OFF: assert property (@(posedge clk) disable iff (!nrst)
        (ifb.edge_sel == EDGE_OFF || !ifb.src_ok) |-> !ifb.fire)
        else $error("channel B captured while disabled");

    AST_MODE_LEGAL: assert property (@(posedge clk) disable iff (!nrst)
        (param_wr && param_addr == OFS_A_MODE && param_wdata > 16'h0001) |=> $stable(a_mode_q))
        else $error("illegal trigger mode was accepted");

    AST_AUX_PAIR: assert property (@(posedge clk) disable iff (!nrst)
        (a_low_q == SRC_LAST_LOW && a_high_q == SRC_LAST_LOW + 16'h0001)
            |-> (ifa.src_ok && a_sel.idx == SRC_IDX_AUX))
        else $error("auxiliary position pair not decoded");

    AST_JOINT: assert property (@(posedge clk) disable iff (!nrst)
        (a_low_q == STATOR_LOW && a_high_q != STATOR_HIGH) |-> !ifa.src_ok)
        else $error("low code alone selected a source");

    AST_HOLD_A: assert property (@(posedge clk) disable iff (!nrst)
        !ifa.fire |=> $stable(ifa.value))
        else $error("channel A value changed without capture");

    AST_REARM_A: assert property (@(posedge clk) disable iff (!nrst)
        (ifa.rearm && !ifa.fire) |=> !ifa.done)
        else $error("re-arm did not clear channel A");

    AST_READ_A: assert property (@(posedge clk) disable iff (!nrst)
        (param_rd && param_addr == OFS_A_VALUE)
            |=> (param_rvalid && param_rdata == $past(ifa.value)))
        else $error("read of channel A value wrong");

endmodule : etsc_capture

// ### tb/etsc_pin_model.sv
`timescale 1ns/100ps
module etsc_pin_model
(
    // Clock
    input  wire logic clk,
    // Trigger pins
    output      logic cap_a_pin,
    output      logic cap_b_pin
);
    initial
    begin
        cap_a_pin = 1'b0;
        cap_b_pin = 1'b0;
    end

    // Levels move on the falling edge so the sampling edge never sees a race
    task automatic set_pin(input bit ch_b, input logic lvl);
        @(negedge clk);
        if (ch_b)
            cap_b_pin = lvl;
        else
            cap_a_pin = lvl;
    endtask : set_pin
endmodule : etsc_pin_model

// ### tb/tb_edge_triggered_signal_capture.sv
`timescale 1ns/100ps
module tb_edge_triggered_signal_capture
    import etsc_pkg::*;
;
    logic                         clk;
    logic                         nrst;
    wire logic                    cap_a_pin;
    wire logic                    cap_b_pin;
    logic [NUM_SRC-1:0][31:0]     src;
    logic [15:0]                  addr;
    logic [15:0]                  wdata;
    logic                         wr;
    logic                         rd;
    logic [31:0]                  rdata;
    logic                         rvalid;
    logic                         ev_a;
    logic                         ev_b;
    logic [31:0]                  seed;
    logic [31:0]                  vr;
    logic [31:0]                  vf;
    logic [31:0]                  ve;
    int                           bad_count;
    int                           total_checks;
    int                           cyc;
    int                           n_a;
    int                           n_b;
    int                           a0;
    int                           b0;
    int                           code_list [4] = '{1, 2, 3, 0};
    logic [15:0]                  rst_ofs [8] = '{OFS_A_EDGE, OFS_A_MODE, OFS_A_LOW, OFS_A_HIGH,
                                                  OFS_B_EDGE, OFS_B_MODE, OFS_B_LOW, OFS_B_HIGH};
    logic [31:0]                  rst_val [8] = '{0, 0, 16, 17, 0, 0, 16, 17};

    etsc_pin_model i_etsc_pin_model (.clk(clk), .cap_a_pin(cap_a_pin), .cap_b_pin(cap_b_pin));

    etsc_capture #(.DW(32)) i_etsc_capture (
        .clk(clk), .nrst(nrst), .cap_a_pin(cap_a_pin), .cap_b_pin(cap_b_pin), .src_i(src),
        .param_addr(addr), .param_wr(wr), .param_wdata(wdata), .param_rd(rd),
        .param_rdata(rdata), .param_rvalid(rvalid), .cap_a_event(ev_a), .cap_b_event(ev_b));

    ////////////////////////////////////////////////////////////////////////////
    initial clk = 1'b0;
    always #4 clk = ~clk;

    always @(posedge clk)
    begin
        cyc++;
        if (ev_a === 1'b1) n_a++;
        if (ev_b === 1'b1) n_b++;
        // Whole run needs well under two thousand cycles
        if (cyc == 6000)
        begin
            bad_count++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    function automatic logic [31:0] exp_events(input int code);
        // One rising and one falling edge per run
        return (code == 3) ? 32'h2 : (code == 0) ? 32'h0 : 32'h1;
    endfunction : exp_events

    task automatic test_done();
        if (bad_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask : chk

    task automatic wr_p(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        wr    = 1'b1;
        addr  = a;
        wdata = d;
        @(negedge clk);
        wr    = 1'b0;
    endtask : wr_p

    task automatic rd_p(input logic [15:0] a, input logic [31:0] exp, input string name);
        @(negedge clk);
        rd   = 1'b1;
        addr = a;
        @(negedge clk);
        rd   = 1'b0;
        chk("rvalid", 32'h1, {31'h0, rvalid});
        chk(name, exp, rdata);
    endtask : rd_p

    task automatic new_src();
        for (int i = 0; i < NUM_SRC; i++)
        begin
            seed   = lfsr(seed);
            src[i] = seed;
        end
    endtask : new_src

    // Rise then fall; a fresh source set is presented for each edge
    task automatic two_edges(input bit ch_b, input int idx);
        a0 = n_a;
        b0 = n_b;
        new_src();
        vr = src[idx];
        i_etsc_pin_model.set_pin(ch_b, 1'b1);
        repeat (4) @(negedge clk);
        new_src();
        vf = src[idx];
        i_etsc_pin_model.set_pin(ch_b, 1'b0);
        repeat (6) @(negedge clk);
    endtask : two_edges

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        nrst  = 1'b0;
        wr    = 1'b0;
        rd    = 1'b0;
        addr  = 16'h0000;
        wdata = 16'h0000;
        src   = '0;
        seed  = 32'h8E96;
        ve    = 32'h0;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        for (int i = 0; i < 8; i++)
            rd_p(rst_ofs[i], rst_val[i], "reset_value");
        rd_p(OFS_A_VALUE, 32'h0, "value_a_reset");
        rd_p(OFS_STATUS, 32'h0, "status_reset");

        // Channel A continuous over every edge code; B must stay quiet
        wr_p(OFS_A_MODE, 16'h0001);
        for (int i = 0; i < 4; i++)
        begin
            wr_p(OFS_A_EDGE, 16'(code_list[i]));
            two_edges(1'b0, 0);
            chk("events_a", exp_events(code_list[i]), 32'(n_a - a0));
            chk("events_b", 32'h0, 32'(n_b - b0));
            // Edge code off keeps whatever the previous run left behind
            if (code_list[i] == 1)
                ve = vr;
            else if (code_list[i] != 0)
                ve = vf;
            rd_p(OFS_A_VALUE, ve, "value_a");
        end

        // Single mode: one capture until re-armed
        wr_p(OFS_A_EDGE, 16'h0001);
        wr_p(OFS_A_MODE, 16'h0000);
        wr_p(OFS_REARM, 16'h0001);
        two_edges(1'b0, 0);
        a0 = a0 - 0;
        chk("single_first", 32'h1, 32'(n_a - a0));
        rd_p(OFS_A_VALUE, vr, "value_a_single");
        rd_p(OFS_STATUS, 32'h1, "status_done");
        two_edges(1'b0, 0);
        chk("single_blocked", 32'h0, 32'(n_a - a0));
        wr_p(OFS_REARM, 16'h0001);
        rd_p(OFS_STATUS, 32'h0, "status_rearmed");
        two_edges(1'b0, 0);
        chk("single_rearmed", 32'h1, 32'(n_a - a0));
        rd_p(OFS_A_VALUE, vr, "value_a_rearmed");

        // Re-arm written in the very cycle of a capture: the capture wins
        wr_p(OFS_REARM, 16'h0001);
        i_etsc_pin_model.set_pin(1'b0, 1'b1);
        @(negedge clk);
        wr_p(OFS_REARM, 16'h0001);
        rd_p(OFS_STATUS, 32'h1, "status_set_wins");
        i_etsc_pin_model.set_pin(1'b0, 1'b0);

        // Out-of-range settings are ignored
        wr_p(OFS_A_EDGE, 16'h0004);
        rd_p(OFS_A_EDGE, 32'h1, "edge_refused");
        wr_p(OFS_A_MODE, 16'h0002);
        rd_p(OFS_A_MODE, 32'h0, "mode_refused");

        // Channel B walks every source pair, then one broken pair
        wr_p(OFS_B_EDGE, 16'h0003);
        wr_p(OFS_B_MODE, 16'h0001);
        for (int s = 0; s < NUM_SRC; s++)
        begin
            wr_p(OFS_B_LOW, (s == 10) ? 16'h000F : (s == 11) ? 16'h0056 : 16'(16 + 2 * s));
            wr_p(OFS_B_HIGH, (s >= 10) ? 16'h0057 : 16'(17 + 2 * s));
            two_edges(1'b1, s);
            chk("events_b_src", 32'h2, 32'(n_b - b0));
            chk("events_a_idle", 32'h0, 32'(n_a - a0));
            rd_p(OFS_B_VALUE, vf, "value_b");
        end

        // Channel A on the auxiliary pair, then a low code without its partner
        wr_p(OFS_A_MODE, 16'h0001);
        wr_p(OFS_A_EDGE, 16'h0003);
        wr_p(OFS_A_LOW, 16'h0022);
        wr_p(OFS_A_HIGH, 16'h0023);
        two_edges(1'b0, 9);
        chk("events_a_aux", 32'h2, 32'(n_a - a0));
        rd_p(OFS_A_VALUE, vf, "value_a_aux");
        wr_p(OFS_A_LOW, 16'h0056);
        two_edges(1'b0, 0);
        chk("events_a_joint", 32'h0, 32'(n_a - a0));

        wr_p(OFS_B_LOW, 16'h0010);
        wr_p(OFS_B_HIGH, 16'h0013);
        two_edges(1'b1, 0);
        chk("events_b_badpair", 32'h0, 32'(n_b - b0));
        test_done();
    end
endmodule : tb_edge_triggered_signal_capture
